// ---- hdl/fpr_pkg.sv ----
// Constants shared by the fuse PROM program/read sequencer and its pulse generator.
// Assumes a 200 MHz system clock.
package fpr_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int PW_MIN_NS = 1000;
    localparam int PW_MAX_NS = 8000;
    localparam int TAIL_NS = 100000;
    localparam int BLOWN_NS = 1000;
    localparam int PW_MIN_CYC = (PW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PW_MAX_CYC = PW_MAX_NS / CLK_PERIOD_NS;
    localparam int TAIL_CYC = (TAIL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLOWN_CYC = (BLOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PW_STEP_CYC = 1;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_ADDR = 5'h04;
    localparam logic [4:0] OFS_WDATA = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0C;
    localparam logic [4:0] OFS_RDATA = 5'h10;
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_IDX_LSB = 4;
    localparam int ST_RANGE_N = 0;
    localparam int ST_BLOWN_N = 1;
    localparam int ST_SENSED = 2;
    localparam int ST_WBIT = 3;
    localparam int ST_HV = 4;
    localparam int ST_HWERR = 5;
    localparam int ST_ACTIVE = 6;
    localparam int ST_DONE = 7;
    localparam int ADDR_W = 12;
    localparam int PROM_ADDR_W = 9;
endpackage

// ---- hdl/fpr_pulse_gen.sv ----
// Programming pulse train generator with a widening pulse ramp and a post-blow tail.
// Assumes start is a one-cycle pulse issued only while run is high.
`timescale 1ns/100ps
module fpr_pulse_gen #(
    parameter int TAIL_CYC = fpr_pkg::TAIL_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    fpr_pulse_if.gen pif
);
    typedef enum logic [3:0] {
        S_IDLE = 4'h1, S_ON = 4'h2, S_OFF = 4'h4, S_DONE = 4'h8
    } fpr_pstate_t;
    fpr_pstate_t state_reg;
    fpr_pstate_t state_next;
    logic [15:0] width_reg;
    logic [15:0] cnt_reg;
    logic [15:0] tail_reg;
    logic tail_on_reg;
    logic pulse_reg;
    logic active_reg;
    logic done_reg;
    logic cnt_end;
    logic tail_end;

    assign cnt_end = (cnt_reg == width_reg - 16'h0001);
    assign tail_end = tail_on_reg && (tail_reg == 16'(TAIL_CYC - 1));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: if (pif.start) state_next = S_ON;
            S_ON: begin
                if (!pif.run) state_next = S_IDLE;
                else if (tail_end) state_next = S_DONE;
                else if (cnt_end) state_next = S_OFF;
            end
            S_OFF: begin
                if (!pif.run) state_next = S_IDLE;
                else if (tail_end) state_next = S_DONE;
                else if (cnt_end) state_next = S_ON;
            end
            S_DONE: if (!pif.run) state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) state_reg <= S_IDLE;
        else state_reg <= state_next;
    end

    always_ff @(posedge mclk) begin
        if (reset || state_next != state_reg) cnt_reg <= 16'h0000;
        else cnt_reg <= cnt_reg + 16'h0001;
    end

    always_ff @(posedge mclk) begin
        if (reset || pif.start) begin
            width_reg <= 16'(fpr_pkg::PW_MIN_CYC);
        end else if (state_reg == S_OFF && state_next == S_ON) begin
            if (width_reg < 16'(fpr_pkg::PW_MAX_CYC - fpr_pkg::PW_STEP_CYC))
                width_reg <= width_reg + 16'(fpr_pkg::PW_STEP_CYC);
            else
                width_reg <= 16'(fpr_pkg::PW_MAX_CYC);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || pif.start || !pif.run) begin
            tail_on_reg <= 1'b0;
            tail_reg <= 16'h0000;
        end else if (tail_on_reg) begin
            tail_reg <= tail_reg + 16'h0001;
        end else if (pif.blown && (state_reg == S_ON || state_reg == S_OFF)) begin
            tail_on_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pulse_reg <= 1'b0;
            active_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            pulse_reg <= (state_next == S_ON);
            active_reg <= (state_next == S_ON) || (state_next == S_OFF);
            done_reg <= (state_next == S_DONE);
        end
    end

    assign pif.pulse = pulse_reg;
    assign pif.active = active_reg;
    assign pif.done = done_reg;

    AST_PW_RANGE: assert property (@(posedge mclk) disable iff (reset)
        state_reg != S_IDLE |-> width_reg >= 16'(fpr_pkg::PW_MIN_CYC)
            && width_reg <= 16'(fpr_pkg::PW_MAX_CYC))
        else $error("Pulse width left its allowed range.");

    AST_TAIL_LEN: assert property (@(posedge mclk) disable iff (reset)
        state_reg != S_DONE && state_next == S_DONE |-> tail_reg == 16'(TAIL_CYC - 1))
        else $error("Pulse train ended before the full tail.");
endmodule // fpr_pulse_gen

// ---- hdl/fpr_pulse_if.sv ----
// Link between the sequencer control logic and its pulse generator.
// Assumes both ends share one clock.
`timescale 1ns/100ps
interface fpr_pulse_if;
    logic start;
    logic run;
    logic blown;
    logic pulse;
    logic active;
    logic done;
    modport ctl (output start, output run, output blown, input pulse, input active, input done);
    modport gen (input start, input run, input blown, output pulse, output active, output done);
endinterface

// ---- hdl/fpr_sequencer.sv ----
// Fuse PROM program/read sequencer: Avalon-MM register slave, socket drivers and sensing.
// Assumes a synchronous active-high reset and PROM socket inputs synchronous to mclk.
`timescale 1ns/100ps
module fpr_sequencer #(
    parameter int TAIL_CYC = fpr_pkg::TAIL_CYC
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic hv_present,
    input wire logic [7:0] prom_data_in,
    output logic [7:0] prom_data_out,
    output logic [7:0] prom_data_oe,
    output logic [8:0] prom_addr,
    output logic chip_select_pulse_n,
    output logic pulsed_supply,
    output logic address_range_err_n,
    output logic selected_write_bit,
    output logic fuse_blown_n,
    output logic sensed_bit,
    output logic [7:0] rd_data_n,
    output logic hw_error
);
    fpr_pulse_if pif ();

    logic sel_reg;
    logic sel_q_reg;
    logic [2:0] idx_reg;
    logic [11:0] addr_reg;
    logic [7:0] wdata_reg;
    logic start_reg;
    logic range_n_reg;
    logic wbit_reg;
    logic sensed_reg;
    logic sensed_q_reg;
    logic blown_n_reg;
    logic [15:0] blown_cnt_reg;
    logic blown_evt;
    logic hwerr_reg;
    logic [7:0] rdn_reg;
    logic [7:0] dout_reg;
    logic [7:0] doe_reg;
    logic [8:0] paddr_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic req;
    logic wr_go;
    logic addr_ok;
    logic [31:0] status_word;

    // Decoder shared by the drive-enable and drive-data lines.
    function automatic logic [7:0] pos_decode(input logic [2:0] idx);
        pos_decode = 8'h01 << idx;
    endfunction

    // Bus slave: every access answers one cycle after it is seen.
    assign req = avs_read || avs_write;
    assign wr_go = avs_write && !wait_reg;

    always_ff @(posedge mclk) begin
        if (reset) wait_reg <= 1'b1;
        else if (req && wait_reg) wait_reg <= 1'b0;
        else wait_reg <= 1'b1;
    end

    assign status_word = {
        24'h000000,
        pif.done,
        pif.active,
        hwerr_reg,
        hv_present,
        wbit_reg,
        sensed_reg,
        blown_n_reg,
        range_n_reg
    };

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_reg <= 32'h00000000;
        end else if (avs_read && wait_reg) begin
            unique case (avs_address)
                fpr_pkg::OFS_CTRL:
                    rdata_reg <= {25'h0000000, idx_reg, 3'h0, sel_reg};
                fpr_pkg::OFS_ADDR: rdata_reg <= {20'h00000, addr_reg};
                fpr_pkg::OFS_WDATA: rdata_reg <= {24'h000000, wdata_reg};
                fpr_pkg::OFS_STATUS: rdata_reg <= status_word;
                fpr_pkg::OFS_RDATA: rdata_reg <= {24'h000000, rdn_reg};
                default: rdata_reg <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sel_reg <= 1'b0;
            idx_reg <= 3'h0;
        end else if (wr_go && avs_address == fpr_pkg::OFS_CTRL && avs_byteenable[0]) begin
            sel_reg <= avs_writedata[fpr_pkg::CTRL_SEL_BIT];
            idx_reg <= avs_writedata[fpr_pkg::CTRL_IDX_LSB +: 3];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            addr_reg <= 12'h000;
        end else if (wr_go && avs_address == fpr_pkg::OFS_ADDR) begin
            if (avs_byteenable[0]) addr_reg[7:0] <= avs_writedata[7:0];
            if (avs_byteenable[1]) addr_reg[11:8] <= avs_writedata[11:8];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) wdata_reg <= 8'h00;
        else if (wr_go && avs_address == fpr_pkg::OFS_WDATA && avs_byteenable[0])
            wdata_reg <= avs_writedata[7:0];
    end

    assign addr_ok = (addr_reg[11:9] == 3'h0);

    always_ff @(posedge mclk) begin
        if (reset) begin
            range_n_reg <= 1'b1;
            paddr_reg <= 9'h000;
        end else begin
            range_n_reg <= addr_ok;
            paddr_reg <= addr_reg[8:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            sel_q_reg <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            sel_q_reg <= sel_reg;
            start_reg <= sel_reg && !sel_q_reg && addr_ok && hv_present;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            hwerr_reg <= 1'b0;
        end else if (sel_reg && !sel_q_reg && addr_ok && !hv_present) begin
            hwerr_reg <= 1'b1;
        end else if (wr_go && avs_address == fpr_pkg::OFS_STATUS && avs_byteenable[0]
                     && avs_writedata[fpr_pkg::ST_HWERR]) begin
            hwerr_reg <= 1'b0;
        end
    end

    assign pif.start = start_reg;
    assign pif.run = sel_reg;
    assign pif.blown = blown_evt;

    fpr_pulse_gen #(
        .TAIL_CYC(TAIL_CYC)
    ) u_pulse (
        .mclk(mclk),
        .reset(reset),
        .pif(pif.gen)
    );

    always_ff @(posedge mclk) begin
        if (reset) wbit_reg <= 1'b0;
        else wbit_reg <= wdata_reg[idx_reg];
    end

    // Inverted sensed bit.
    // During programming the line is only meaningful between pulses, so it is held while a pulse is on.
    always_ff @(posedge mclk) begin
        if (reset) begin
            sensed_reg <= 1'b0;
            sensed_q_reg <= 1'b0;
        end else begin
            if (!pif.pulse) sensed_reg <= !prom_data_in[idx_reg];
            sensed_q_reg <= sensed_reg;
        end
    end

    assign blown_evt = sel_reg && sensed_reg && !sensed_q_reg;

    always_ff @(posedge mclk) begin
        if (reset) begin
            blown_n_reg <= 1'b1;
            blown_cnt_reg <= 16'h0000;
        end else if (blown_evt) begin
            blown_n_reg <= 1'b0;
            blown_cnt_reg <= 16'(fpr_pkg::BLOWN_CYC - 1);
        end else if (blown_cnt_reg != 16'h0000) begin
            blown_cnt_reg <= blown_cnt_reg - 16'h0001;
        end else begin
            blown_n_reg <= 1'b1;
        end
    end

    // Only a zero bit is driven.
    always_ff @(posedge mclk) begin
        if (reset) begin
            doe_reg <= 8'h00;
            dout_reg <= 8'h00;
        end else if (pif.active && !wdata_reg[idx_reg]) begin
            doe_reg <= pos_decode(idx_reg);
            dout_reg <= pos_decode(idx_reg) & {8{pif.pulse}};
        end else begin
            doe_reg <= 8'h00;
            dout_reg <= 8'h00;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) rdn_reg <= 8'hFF;
        else if (!sel_reg && addr_ok) rdn_reg <= ~prom_data_in;
        else if (!addr_ok) rdn_reg <= 8'hFF;
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;
    assign prom_data_out = dout_reg;
    assign prom_data_oe = doe_reg;
    assign prom_addr = paddr_reg;
    assign chip_select_pulse_n = pif.pulse;
    assign pulsed_supply = pif.pulse;
    assign address_range_err_n = range_n_reg;
    assign selected_write_bit = wbit_reg;
    assign fuse_blown_n = blown_n_reg;
    assign sensed_bit = sensed_reg;
    assign rd_data_n = rdn_reg;
    assign hw_error = hwerr_reg;

    AST_RANGE: assert property (@(posedge mclk) disable iff (reset)
        addr_reg[11:9] != 3'h0 |=> !address_range_err_n)
        else $error("Range error missing for high address.");

    AST_START: assert property (@(posedge mclk) disable iff (reset)
        $rose(sel_reg) && addr_ok && hv_present |-> ##2 pulsed_supply && pif.active)
        else $error("Pulse train did not start on select rise.");

    AST_READ_LVL: assert property (@(posedge mclk) disable iff (reset)
        !sel_reg |=> !chip_select_pulse_n && !pulsed_supply)
        else $error("Pulse outputs not at read level.");

    AST_ONE_DRIVE: assert property (@(posedge mclk) disable iff (reset)
        $onehot0(prom_data_oe) && (prom_data_out & ~prom_data_oe) == 8'h00)
        else $error("More than one PROM output driven.");

    AST_WBIT: assert property (@(posedge mclk) disable iff (reset)
        1'b1 |=> selected_write_bit == $past(wdata_reg[idx_reg]))
        else $error("Selected write bit does not match index.");

    AST_POS: assert property (@(posedge mclk) disable iff (reset)
        pif.active && !wdata_reg[idx_reg] && $stable(idx_reg)
        |=> prom_data_oe == pos_decode(idx_reg))
        else $error("Drive line does not match bit index.");

    AST_ONESHOT: assert property (@(posedge mclk) disable iff (reset)
        blown_evt |=> !fuse_blown_n [*8])
        else $error("Blown indication did not go low.");

    AST_SENSE: assert property (@(posedge mclk) disable iff (reset)
        !pif.pulse |=> sensed_bit == !$past(prom_data_in[idx_reg]))
        else $error("Sensed bit is not the inverted PROM bit.");

    AST_HV: assert property (@(posedge mclk) disable iff (reset)
        $rose(sel_reg) && addr_ok && !hv_present |=> hw_error ##1 !pif.active)
        else $error("Missing high voltage not reported.");

    AST_RDATA: assert property (@(posedge mclk) disable iff (reset)
        !sel_reg && addr_ok |=> rd_data_n == ~$past(prom_data_in))
        else $error("Read word is not the complemented PROM word.");

    AST_RANGE_BLOCK: assert property (@(posedge mclk) disable iff (reset)
        !addr_ok && !pif.active |=> !start_reg)
        else $error("Pulses started at an out-of-range address.");
endmodule // fpr_sequencer

// ---- sim/fpr_prom_model.sv ----
// Socket model of a 512-word fuse PROM, manufactured with every bit at one.
// Assumes the sequencer drives a bit only to force programming current into it.
`timescale 1ns/100ps
module fpr_prom_model #(
    parameter int BLOW_PULSES = 3
) (
    input wire logic mclk,
    input wire logic [8:0] prom_addr,
    input wire logic [7:0] prom_data_out,
    input wire logic [7:0] prom_data_oe,
    input wire logic chip_select_pulse_n,
    output logic [7:0] prom_data_in
);
    logic [7:0] mem [512];
    logic [7:0] drive_prev;
    int pulse_cnt;

    initial begin
        for (int i = 0; i < 512; i++) begin
            mem[i] = 8'hFF;
        end
        drive_prev = 8'h00;
        pulse_cnt = 0;
    end

    // Forced output wins.
    // A deselected chip floats, so undriven lines show the inverse rather than stale data.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (prom_data_oe[i] && prom_data_out[i])
                prom_data_in[i] = 1'b1;
            else
                prom_data_in[i] = chip_select_pulse_n ? ~mem[prom_addr][i] : mem[prom_addr][i];
        end
    end

    // Fuse opens late.
    // The fuse opens only after several pulses, so the widening ramp is really exercised.
    always @(posedge mclk) begin
        logic [7:0] drv;
        drv = prom_data_oe & prom_data_out;
        if (prom_data_oe == 8'h00)
            pulse_cnt = 0;
        else if ((drv & ~drive_prev) != 8'h00)
            pulse_cnt = pulse_cnt + 1;
        if (pulse_cnt >= BLOW_PULSES && drv == 8'h00)
            mem[prom_addr] <= mem[prom_addr] & ~prom_data_oe;
        drive_prev = drv;
    end
endmodule // fpr_prom_model

// ---- sim/fpr_sequencer_bench.sv ----
// Self-checking bench: register tasks over the slave bus, socket model at the far side.
// Assumes the design package is compiled first and a short tail count is acceptable.
`timescale 1ns/100ps
`define CHECK_EQ(got, exp) begin \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        fails++; \
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module fpr_sequencer_bench;
    logic mclk, reset, avs_read, avs_write, avs_waitrequest, hv_present;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0] prom_data_in, prom_data_out, prom_data_oe, rd_data_n, snap_oe;
    logic [8:0] prom_addr;
    logic chip_select_pulse_n, pulsed_supply, address_range_err_n, selected_write_bit;
    logic fuse_blown_n, sensed_bit, hw_error, snap_cs;
    int fails = 0;
    int cmp_count = 0;
    int w, progs;

    fpr_sequencer #(.TAIL_CYC(50)) uut (.mclk(mclk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hv_present(hv_present),
        .prom_data_in(prom_data_in), .prom_data_out(prom_data_out),
        .prom_data_oe(prom_data_oe), .prom_addr(prom_addr),
        .chip_select_pulse_n(chip_select_pulse_n), .pulsed_supply(pulsed_supply),
        .address_range_err_n(address_range_err_n), .selected_write_bit(selected_write_bit),
        .fuse_blown_n(fuse_blown_n), .sensed_bit(sensed_bit), .rd_data_n(rd_data_n),
        .hw_error(hw_error));

    fpr_prom_model #(.BLOW_PULSES(3)) prom (.mclk(mclk), .prom_addr(prom_addr),
        .prom_data_out(prom_data_out), .prom_data_oe(prom_data_oe),
        .chip_select_pulse_n(chip_select_pulse_n), .prom_data_in(prom_data_in));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Holds the request until waitrequest is seen low at a rising edge, then releases it.
    task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge mclk);
            #1;
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        @(posedge mclk);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 100) fails++;
        #1;
    endtask

    function automatic logic [31:0] ctrl_word(input logic [2:0] idx, input logic sel);
        return (32'(idx) << fpr_pkg::CTRL_IDX_LSB) | 32'(sel);
    endfunction

    // Waits for the pulsed supply to reach a level, then counts the cycles it stays there.
    task automatic span(input logic lvl, output int n);
        int t;
        t = 0;
        n = 0;
        while (pulsed_supply !== lvl && t < 4000) begin
            @(posedge mclk);
            #1;
            t++;
        end
        while (pulsed_supply === lvl && n < 4000) begin
            snap_oe = prom_data_oe;
            snap_cs = chip_select_pulse_n;
            @(posedge mclk);
            #1;
            n++;
        end
    endtask

    task automatic prog_bit(input logic [2:0] idx);
        int t;
        t = 0;
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(idx, 1'b1));
        span(1'b1, w);
        `CHECK_EQ(w, 200)
        `CHECK_EQ(snap_oe, 8'h01 << idx)
        `CHECK_EQ(snap_cs, 1'b1)
        span(1'b0, w);
        `CHECK_EQ(w, 200)
        span(1'b1, w);
        `CHECK_EQ(w, 201)
        while (fuse_blown_n !== 1'b0 && t < 4000) begin
            @(posedge mclk);
            #1;
            t++;
        end
        `CHECK_EQ(fuse_blown_n, 1'b0)
        bus_xfer(1'b0, fpr_pkg::OFS_STATUS, 32'h0);
        `CHECK_EQ(q[fpr_pkg::ST_ACTIVE], 1'b1)
        repeat (100) @(posedge mclk);
        bus_xfer(1'b0, fpr_pkg::OFS_STATUS, 32'h0);
        `CHECK_EQ(q[fpr_pkg::ST_DONE], 1'b1)
        `CHECK_EQ({q[fpr_pkg::ST_ACTIVE], pulsed_supply}, 2'b00)
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(idx, 1'b0));
    endtask

    task automatic test_end(input string name);
        $display("test %s finished, mismatches so far %0d", name, fails);
    endtask

    initial begin
        reset <= 1'b1;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= 5'h00;
        avs_writedata <= 32'h0;
        hv_present <= 1'b1;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        #1;
        `CHECK_EQ({chip_select_pulse_n, pulsed_supply, prom_data_oe}, 10'h000)
        `CHECK_EQ({address_range_err_n, fuse_blown_n, hw_error}, 3'b110)
        test_end("reset");

        prom.mem[5] = 8'hA5;
        bus_xfer(1'b1, fpr_pkg::OFS_ADDR, 32'h5);
        bus_xfer(1'b1, fpr_pkg::OFS_WDATA, 32'h3C);
        bus_xfer(1'b0, fpr_pkg::OFS_RDATA, 32'h0);
        `CHECK_EQ(q, 32'h5A)
        `CHECK_EQ(rd_data_n, 8'h5A)
        `CHECK_EQ(prom_addr, 9'h005)
        for (int i = 0; i < 8; i++) begin
            bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'(i), 1'b0));
            bus_xfer(1'b0, fpr_pkg::OFS_STATUS, 32'h0);
            `CHECK_EQ({q[fpr_pkg::ST_SENSED], sensed_bit}, {2{~prom.mem[5][i]}})
            `CHECK_EQ({q[fpr_pkg::ST_WBIT], selected_write_bit}, {2{1'(8'h3C >> i)}})
        end
        `CHECK_EQ(prom_data_oe, 8'h00)
        test_end("read");

        for (int b = 9; b < 12; b++) begin
            bus_xfer(1'b1, fpr_pkg::OFS_ADDR, (32'h1 << b) | 32'h5);
            bus_xfer(1'b0, fpr_pkg::OFS_STATUS, 32'h0);
            `CHECK_EQ(q[fpr_pkg::ST_RANGE_N], 1'b0)
            `CHECK_EQ(rd_data_n, 8'hFF)
        end
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'h0, 1'b1));
        repeat (20) @(posedge mclk);
        #1;
        `CHECK_EQ({pulsed_supply, prom_data_oe}, 9'h000)
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'h0, 1'b0));
        bus_xfer(1'b1, fpr_pkg::OFS_ADDR, 32'h1FF);
        @(posedge mclk);
        #1;
        `CHECK_EQ(address_range_err_n, 1'b1)
        test_end("range");

        bus_xfer(1'b1, fpr_pkg::OFS_ADDR, 32'h5);
        @(posedge mclk) hv_present <= 1'b0;
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'h0, 1'b1));
        repeat (10) @(posedge mclk);
        #1;
        `CHECK_EQ({hw_error, pulsed_supply}, 2'b10)
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'h0, 1'b0));
        @(posedge mclk) hv_present <= 1'b1;
        bus_xfer(1'b1, fpr_pkg::OFS_STATUS, 32'h1 << fpr_pkg::ST_HWERR);
        `CHECK_EQ(hw_error, 1'b0)
        test_end("no_high_voltage");

        bus_xfer(1'b1, fpr_pkg::OFS_ADDR, 32'h7);
        bus_xfer(1'b1, fpr_pkg::OFS_WDATA, 32'hFE);
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'h0, 1'b1));
        span(1'b0, w);
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'h0, 1'b0));
        repeat (2) @(posedge mclk);
        #1;
        `CHECK_EQ({chip_select_pulse_n, pulsed_supply, prom_data_oe}, 10'h000)
        // A dropped select is retried and the ramp starts again.
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'h0, 1'b1));
        span(1'b1, w);
        `CHECK_EQ(w, 200)
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'h0, 1'b0));
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'h1, 1'b1));
        repeat (300) @(posedge mclk);
        #1;
        `CHECK_EQ(prom_data_oe, 8'h00)
        bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'h1, 1'b0));
        test_end("abort");

        progs = 0;
        bus_xfer(1'b1, fpr_pkg::OFS_ADDR, 32'h3);
        bus_xfer(1'b1, fpr_pkg::OFS_WDATA, 32'hDB);
        // Bits taken in turn; a stored one wanted as zero is programmed.
        for (int i = 0; i < 8; i++) begin
            bus_xfer(1'b1, fpr_pkg::OFS_CTRL, ctrl_word(3'(i), 1'b0));
            bus_xfer(1'b0, fpr_pkg::OFS_STATUS, 32'h0);
            if (q[fpr_pkg::ST_WBIT] === 1'b0 && q[fpr_pkg::ST_SENSED] === 1'b0) begin
                prog_bit(3'(i));
                progs++;
            end
        end
        `CHECK_EQ(progs, 2)
        bus_xfer(1'b0, fpr_pkg::OFS_RDATA, 32'h0);
        `CHECK_EQ(q, 32'h24)
        test_end("program");
        final_report();
    end

    // Whole run needs well under ten thousand cycles; this cuts a hang short.
    initial begin
        #(5 * 40000);
        fails++;
        $display("watchdog expired at t=%0t", $time);
        final_report();
    end
endmodule // fpr_sequencer_bench
